// ===== verilog/djkff_pkg.sv
// Behaviour
// RL1: two independent elements, each with own clock, steering, preset, clear and outputs.
// RL2: preset low, clear high forces true output high, complement low, clock ignored.
// RL3: clear low, preset high forces true output low, complement high.
// RL4: both overrides low drive both outputs high; not retained after release.
// RL5: overrides high, falling edge: hold, set, reset or toggle; complement mirrors.
// RL6: steering changes ignored except at the falling clock edge.
// RL7: driving logic holds both steering inputs high for divide-by-two toggling.
// RL8: state after power-up undefined; driving logic pulses preset or clear first.
package djkff_pkg;
  localparam int unsigned DJKFF_NUM_ELEM = 2;
  localparam logic DJKFF_STATE_RESET = 1'h0;
  localparam logic DJKFF_QN_RESET = 1'h1;
  localparam logic DJKFF_CLK_IDLE = 1'h1;
  // synchroniser reset values, idle low and idle high pins
  localparam logic [1:0] DJKFF_SYNC_LOW = 2'h0;
  localparam logic [1:0] DJKFF_SYNC_HIGH = 2'h3;
  // steering encodings, {first, second}
  localparam logic [1:0] DJKFF_JK_HOLD = 2'h0;
  localparam logic [1:0] DJKFF_JK_RESET = 2'h1;
  localparam logic [1:0] DJKFF_JK_SET = 2'h2;
  localparam logic [1:0] DJKFF_JK_TOGGLE = 2'h3;
endpackage

// ===== verilog/djkff_top.sv
`timescale 1ns/1ps
// two jk elements, each sampling its own pin clock on the system clock
module djkff_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [1:0] elem_clk_i,
  input wire logic [1:0] steer_set_i,
  input wire logic [1:0] steer_reset_i,
  input wire logic [1:0] async_preset_n_i,
  input wire logic [1:0] async_clear_n_i,
  output logic [1:0] q_o,
  output logic [1:0] q_n_o
);
  // next stored state from steering and current state:
  // hold, set, reset or invert, as the steering pair selects
  function automatic logic djkff_next(input logic [1:0] jk, input logic cur);
    case (jk)
      djkff_pkg::DJKFF_JK_HOLD: djkff_next = cur;
      djkff_pkg::DJKFF_JK_SET: djkff_next = 1'h1;
      djkff_pkg::DJKFF_JK_RESET: djkff_next = 1'h0;
      djkff_pkg::DJKFF_JK_TOGGLE: djkff_next = ~cur;
      default: djkff_next = cur;
    endcase
  endfunction

  // two-stage shift for a pin synchroniser:
  // oldest sample drops out, newest pin level enters
  function automatic logic [1:0] djkff_shift(input logic [1:0] stages, input logic pin);
    djkff_shift = {stages[0], pin};
  endfunction

  // an active-low override counts only once it has passed
  // both stages, so a metastable first stage is never read
  function automatic logic djkff_active(input logic [1:0] stages);
    djkff_active = ~stages[1];
  endfunction

  genvar g;
  generate
    for (g = 0; g < djkff_pkg::DJKFF_NUM_ELEM; g++) begin : g_elem // RL1
      // latency in system clock edges, counted from the edge that
      // first samples a pin change: overrides and falling pin clocks
      // both reach the outputs on the third edge; pin pulses shorter
      // than one system clock period may be missed, as may steering
      // that changes within one period of the pin clock falling

      // pin synchronisers, two stages each
      logic [1:0] clk_sync_r;
      logic clk_prev_r;
      logic [1:0] set_sync_r;
      logic [1:0] rst_sync_r;
      logic [1:0] pre_sync_r;
      logic [1:0] clr_sync_r;

      // stored state and registered outputs
      logic state_r;
      logic state_nxt;
      logic q_r;
      logic q_nxt;
      logic q_n_r;
      logic q_n_nxt;

      // override decode
      wire pre_act;
      wire clr_act;
      wire pre_only;
      wire clr_only;
      wire both_act;
      wire none_act;

      // edge and steering decode
      wire fall_edge;
      wire [1:0] steer_sel;
      wire steer_next;

      // element clock pin, two flops before anything reads it;
      // resets to the pin's idle high level so that reset release
      // cannot look like a falling edge
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          clk_sync_r <= djkff_pkg::DJKFF_SYNC_HIGH;
        end else if (clk_en_i) begin
          clk_sync_r <= djkff_shift(clk_sync_r, elem_clk_i[g]);
        end
      end

      // first steering pin, same depth as the clock pin
      // so the pair and the detected edge stay aligned
      // in one and the same cycle
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          set_sync_r <= djkff_pkg::DJKFF_SYNC_LOW;
        end else if (clk_en_i) begin
          set_sync_r <= djkff_shift(set_sync_r, steer_set_i[g]);
        end
      end

      // second steering pin, same depth as the clock pin
      // so the pair and the detected edge stay aligned
      // in one and the same cycle
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          rst_sync_r <= djkff_pkg::DJKFF_SYNC_LOW;
        end else if (clk_en_i) begin
          rst_sync_r <= djkff_shift(rst_sync_r, steer_reset_i[g]);
        end
      end

      // preset pin; resets inactive so that reset release
      // forces nothing; the override is slower than a bare
      // pin by the synchroniser depth
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          pre_sync_r <= djkff_pkg::DJKFF_SYNC_HIGH;
        end else if (clk_en_i) begin
          pre_sync_r <= djkff_shift(pre_sync_r, async_preset_n_i[g]);
        end
      end

      // clear pin; same depth as preset so that a pair
      // released together is seen released together
      // and no single-override cycle slips in between
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          clr_sync_r <= djkff_pkg::DJKFF_SYNC_HIGH;
        end else if (clk_en_i) begin
          clr_sync_r <= djkff_shift(clr_sync_r, async_clear_n_i[g]);
        end
      end

      // clock level one edge back, for the edge detector;
      // it reads only the second stage, never the first,
      // and resets high to match the idle pin
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          clk_prev_r <= djkff_pkg::DJKFF_CLK_IDLE;
        end else if (clk_en_i) begin
          clk_prev_r <= clk_sync_r[1];
        end
      end

      // falling edge of the pin clock; rising edges and
      // steady levels are never acted on, so steering may
      // change freely outside the falling edge
      assign fall_edge = clk_prev_r & ~clk_sync_r[1]; // RL6

      // override decode from the synchronised pins; a pair released
      // together is seen released in the same cycle
      assign pre_act = djkff_active(pre_sync_r);
      assign clr_act = djkff_active(clr_sync_r);
      assign pre_only = pre_act & ~clr_act; // RL2
      assign clr_only = clr_act & ~pre_act; // RL3
      assign both_act = pre_act & clr_act; // RL4
      assign none_act = ~pre_act & ~clr_act;

      // steering pair {first, second} and the state it selects
      // at the detected edge; used only while no override
      // is active
      assign steer_sel = {set_sync_r[1], rst_sync_r[1]};
      assign steer_next = djkff_next(steer_sel, state_r); // RL5

      // overrides first, then steering on the falling edge only;
      // both overrides low keep the old state, so the both-high
      // outputs are not retained once either override lifts
      always_comb begin
        state_nxt = state_r;
        if (pre_only) begin
          state_nxt = 1'h1; // RL2
        end else if (clr_only) begin
          state_nxt = 1'h0; // RL3
        end else if (both_act) begin
          state_nxt = state_r; // RL4
        end else if (none_act && fall_edge) begin
          state_nxt = steer_next; // RL5
        end
      end

      // stored state; frozen while the clock enable is low
      // and cleared by the system reset or the clear override
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          state_r <= djkff_pkg::DJKFF_STATE_RESET;
        end else if (clk_en_i) begin
          state_r <= state_nxt;
        end
      end

      // both overrides low drive both outputs high,
      // otherwise the outputs follow the next state
      // so they move on the same edge as the state
      assign q_nxt = both_act | state_nxt; // RL4
      assign q_n_nxt = both_act | ~state_nxt; // RL4 RL5

      // true output flop
      // low during reset, like the stored state
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          q_r <= djkff_pkg::DJKFF_STATE_RESET;
        end else if (clk_en_i) begin
          q_r <= q_nxt;
        end
      end

      // complement output flop
      // high during reset, mirroring the true output
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          q_n_r <= djkff_pkg::DJKFF_QN_RESET;
        end else if (clk_en_i) begin
          q_n_r <= q_n_nxt;
        end
      end

      // registered outputs onto the element's bit of each port;
      // no bit is shared with the other element
      assign q_o[g] = q_r;
      assign q_n_o[g] = q_n_r;
    end
  endgenerate
endmodule

// ===== testbench/djkff_props.sv
`timescale 1ns/1ps
module djkff_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [1:0] elem_clk_i,
  input wire logic [1:0] steer_set_i,
  input wire logic [1:0] steer_reset_i,
  input wire logic [1:0] async_preset_n_i,
  input wire logic [1:0] async_clear_n_i,
  input wire logic [1:0] q_o,
  input wire logic [1:0] q_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || !clk_en_i);
  wire [1:0] p = async_preset_n_i;
  wire [1:0] c = async_clear_n_i;
  // element 0 settled, clock high, both steering inputs high
  sequence s_ready;
    (p[0] && c[0] && steer_set_i[0] && steer_reset_i[0] && elem_clk_i[0])[*4];
  endsequence
  // element 0 clock seen low, steering still high
  sequence s_fall;
    p[0] && c[0] && steer_set_i[0] && steer_reset_i[0] && !elem_clk_i[0];
  endsequence
  property p_toggle; s_ready ##1 s_fall |-> ##3 (q_o[0] != $past(q_o[0], 3)); endproperty
  a_toggle: assert property (p_toggle) else $error("toggle");
  property p_mirror; (p[0] && c[0])[*4] |-> q_n_o[0] == !q_o[0]; endproperty
  a_mirror: assert property (p_mirror) else $error("mirror");
  property p_pre; (!p[0] && c[0])[*5] |-> q_o[0] && !q_n_o[0]; endproperty
  a_pre: assert property (p_pre) else $error("preset");
  property p_clr; (p[1] && !c[1])[*5] |-> !q_o[1] && q_n_o[1]; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_both; (!p[0] && !c[0])[*4] |-> q_o[0] && q_n_o[0]; endproperty
  a_both: assert property (p_both) else $error("both low");
  property p_hold; (p[0] && c[0] && elem_clk_i[0])[*6] |=> $stable(q_o[0]); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule

// ===== testbench/djkff_drv.sv
`timescale 1ns/1ps
// element clock source, idles high
module djkff_drv (
  input wire logic clk_i,
  output logic [1:0] elem_clk_o
);
  initial elem_clk_o = 2'h3;
  task automatic pulse(int e);
    repeat (6) @(posedge clk_i);
    #1 elem_clk_o[e] = 1'h0;
    repeat (6) @(posedge clk_i);
    #1 elem_clk_o[e] = 1'h1;
  endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, reset_i = 1, m, en = 1;
  logic [1:0] ec, sj = 2'h0, sk = 2'h0, pn = 2'h3, cn = 2'h3, q, qn;
  int n_fail = 0, cmp_count = 0, j, seed = 32'h529c_e4c5;
  always #25 clk_i = ~clk_i;
  djkff_drv i_drv(.clk_i, .elem_clk_o(ec));
  djkff_top i_dut(.clk_i, .reset_i, .clk_en_i(en), .elem_clk_i(ec), .steer_set_i(sj), .steer_reset_i(sk),
    .async_preset_n_i(pn), .async_clear_n_i(cn), .q_o(q), .q_n_o(qn));
  task chk(logic [1:0] s, x);
    cmp_count++;
    if (s !== x) begin n_fail++; $display("Error %0t %h %h", $time, s, x); end
  endtask
  task ov(int e, logic [1:0] v, x);
    {pn[e], cn[e]} = v;
    repeat (5) @(posedge clk_i);
    #1 chk({q[e], qn[e]}, x);
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    #1 reset_i = 0;
    for (int e = 0; e < 2; e++) begin
      ov(e, 2'h1, 2'h2);
      ov(e, 2'h0, 2'h3);
      ov(e, 2'h2, 2'h1);
      ov(e, 2'h3, 2'h1);
      en = 0;
      {pn[e], cn[e]} = 2'h1;
      repeat (5) @(posedge clk_i);
      #1 chk({q[e], qn[e]}, 2'h1);
      {pn[e], cn[e]} = 2'h3;
      en = 1;
      m = 0;
      for (int i = 0; i < 9; i++) begin
        j = i > 6 ? 3 : $random(seed) & 3;
        {sk[e], sj[e]} = j[1:0];
        m = j == 3 ? !m : j == 1 ? 1'b1 : j == 2 ? 1'b0 : m;
        i_drv.pulse(e);
        chk({q[e], qn[e]}, {m, !m});
      end
      $display("element %0d done", e);
    end
    finish_test();
  end
endmodule
bind djkff_top djkff_props i_props(.*);
